/* hw/obdp_parser.sv */
// request line parser, frame builder and response collector
// assumes host bytes and vehicle bus bytes arrive already on ref_clk
//
// What this block does
// - a line not opening with the letters A and T is a vehicle request, else a local command.
// - each pair of hex characters is checked and packed into one request byte.
// - three header bytes go before the request bytes and one check byte after.
// - more than 14 digits or an odd count discards the line and prints one question mark.
// - characters are held until carriage return, which only ends the line and is never sent.
// - data bytes of messages addressed to us go to the host, without header or check byte; others are only captured.
// - listening ends when the timeout passes quietly; each matching message restarts it.
// - every request gets a reply, NO DATA when nothing addressed to us came back.
// - the timeout argument counts in steps of 4 ms.
// - spaces anywhere in a line are ignored.
// - letters in upper or lower case mean the same.
// - a greater-than prompt is sent when the next line may start.
`timescale 1ns/1ps
module obdp_parser #(
  parameter int TICK_CYC = obdp_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  output logic [7:0] host_tx_data,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  input wire logic [7:0] hdr_prio,
  input wire logic [7:0] hdr_tgt,
  input wire logic [7:0] hdr_src,
  input wire logic [7:0] own_addr,
  input wire logic cks_sel,
  input wire logic [7:0] timeout_arg,
  output logic [7:0] bus_tx_data,
  output logic bus_tx_valid,
  output logic bus_tx_last,
  input wire logic bus_tx_ready,
  input wire logic [7:0] bus_rx_data,
  input wire logic bus_rx_valid,
  input wire logic bus_rx_first,
  input wire logic bus_rx_last,
  output logic bus_rx_ready,
  output logic cmd_line,
  input wire logic [3:0] cap_rd_idx,
  output logic [7:0] cap_rd_data,
  output logic [3:0] cap_len
);
  obdp_pkg::obdp_state_e st, next_st;
  logic [7:0] req [0:6];
  logic [7:0] next_req [0:6];
  logic [7:0] cap [0:obdp_pkg::CAP_DEPTH-1];
  logic [7:0] next_cap [0:obdp_pkg::CAP_DEPTH-1];
  logic [3:0] dig_cnt, next_dig_cnt, send_idx, next_send_idx, msg_pos, next_msg_pos;
  logic [3:0] txt_idx, next_txt_idx, next_cap_len;
  logic [3:0] hi, next_hi;
  logic [2:0] nbytes, next_nbytes;
  logic [1:0] nsp, next_nsp, txt_sel, next_txt_sel, ph, next_ph;
  logic err, next_err, first_a, next_first_a, is_at, next_is_at;
  logic got_any, next_got_any, msg_act, next_msg_act, msg_match, next_msg_match;
  logic pend_v, next_pend_v, eol, next_eol, match_now, tick;
  logic [7:0] tmo_cnt, next_tmo_cnt, tmo_load, cks, next_cks, pend, next_pend, cur, next_cur;
  logic [7:0] next_host_tx_data, next_bus_tx_data, next_cap_rd_data, ch, uc, b;
  logic next_host_tx_valid, next_bus_tx_valid, next_bus_tx_last, next_bus_rx_ready;
  logic next_cmd_line;
  logic [4:0] hv;
  logic [3:0] pos;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_ascii(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic [7:0] text_char(input logic [1:0] sel, input logic [3:0] idx);
    logic [79:0] s;
    logic [3:0] len;
    s = 80'h0;
    len = 4'h0;
    unique case (sel)
      obdp_pkg::TXT_PROMPT: begin s = {obdp_pkg::CH_GT, 72'h0}; len = 4'h1; end
      obdp_pkg::TXT_ERR: begin s = {32'h3f0d0d3e, 48'h0}; len = 4'h4; end
      obdp_pkg::TXT_NODATA: begin s = 80'h4e4f2044415441_0d0d3e; len = 4'ha; end
      obdp_pkg::TXT_EOL: begin s = {16'h0d3e, 64'h0}; len = 4'h2; end
    endcase
    return (idx < len) ? s[79 - 8 * idx -: 8] : 8'h00;
  endfunction

  function automatic logic [7:0] cks_fold(input logic sel, input logic [7:0] a, input logic [7:0] d);
    return (sel == obdp_pkg::CKS_SUM) ? a + d : a ^ d;
  endfunction

  obdp_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(st == obdp_pkg::OBDP_LISTEN || st == obdp_pkg::OBDP_HEXOUT),
    .restart(match_now),
    .tick(tick)
  );

  assign tmo_load = (timeout_arg == 8'h00) ? 8'h01 : timeout_arg;
  assign pos = bus_rx_first ? 4'h0 : msg_pos;
  assign match_now = st == obdp_pkg::OBDP_LISTEN && bus_rx_valid && bus_rx_ready
    && pos == 4'h1 && bus_rx_data == own_addr;

  always_comb begin
    next_st = st; next_req = req; next_cap = cap; next_cap_len = cap_len;
    next_dig_cnt = dig_cnt; next_send_idx = send_idx; next_msg_pos = msg_pos;
    next_txt_idx = txt_idx; next_hi = hi; next_nbytes = nbytes; next_nsp = nsp;
    next_txt_sel = txt_sel; next_ph = ph; next_err = err; next_first_a = first_a;
    next_is_at = is_at; next_got_any = got_any; next_msg_act = msg_act;
    next_msg_match = msg_match; next_pend_v = pend_v; next_eol = eol;
    next_tmo_cnt = tmo_cnt; next_cks = cks; next_pend = pend; next_cur = cur;
    next_host_tx_data = host_tx_data; next_bus_tx_data = bus_tx_data;
    next_host_tx_valid = host_tx_valid && !host_tx_ready;
    next_bus_tx_valid = bus_tx_valid && !bus_tx_ready;
    next_bus_tx_last = bus_tx_last;
    next_cmd_line = 1'b0;
    next_cap_rd_data = (cap_rd_idx < 4'(obdp_pkg::CAP_DEPTH)) ? cap[cap_rd_idx] : 8'h00;
    uc = to_upper(host_rx_data);
    hv = hex_val(uc);
    ch = text_char(txt_sel, txt_idx);
    b = cks;
    unique case (st)
      obdp_pkg::OBDP_COLLECT: begin
        if (host_rx_valid && host_rx_data == obdp_pkg::CH_CR) begin
          next_dig_cnt = 4'h0; next_nsp = 2'h0; next_err = 1'b0;
          next_first_a = 1'b0; next_is_at = 1'b0; next_txt_idx = 4'h0;
          next_st = obdp_pkg::OBDP_TEXT; next_txt_sel = obdp_pkg::TXT_PROMPT;
          if (is_at) begin
            next_cmd_line = 1'b1;
          end else if (nsp != 2'h0 && (err || dig_cnt > obdp_pkg::MAX_DIGITS || dig_cnt[0])) begin
            next_txt_sel = obdp_pkg::TXT_ERR;
          end else if (nsp != 2'h0) begin
            next_st = obdp_pkg::OBDP_SEND; next_nbytes = dig_cnt[3:1];
            next_send_idx = 4'h0; next_cks = 8'h00;
          end
        end else if (host_rx_valid && host_rx_data != obdp_pkg::CH_SP) begin
          if (nsp == 2'h0) next_first_a = uc == obdp_pkg::CH_A;
          if (nsp == 2'h1) next_is_at = first_a && uc == obdp_pkg::CH_T;
          if (nsp != 2'h2) next_nsp = nsp + 2'h1;
          if (!hv[4]) next_err = 1'b1;
          if (dig_cnt < obdp_pkg::MAX_DIGITS) begin
            if (!dig_cnt[0]) next_hi = hv[3:0];
            else next_req[dig_cnt[3:1]] = {hi, hv[3:0]};
          end
          if (dig_cnt != obdp_pkg::DIG_OVER) next_dig_cnt = dig_cnt + 4'h1;
        end
      end
      obdp_pkg::OBDP_TEXT: begin
        if (!host_tx_valid || host_tx_ready) begin
          if (ch == 8'h00) begin
            next_st = obdp_pkg::OBDP_COLLECT;
          end else begin
            next_host_tx_data = ch; next_host_tx_valid = 1'b1; next_txt_idx = txt_idx + 4'h1;
          end
        end
      end
      obdp_pkg::OBDP_SEND: begin
        if (!bus_tx_valid || bus_tx_ready) begin
          if (send_idx == {1'b0, nbytes} + obdp_pkg::FRAME_EXTRA) begin
            next_st = obdp_pkg::OBDP_LISTEN; next_tmo_cnt = tmo_load; next_got_any = 1'b0;
            next_msg_act = 1'b0; next_msg_match = 1'b0; next_pend_v = 1'b0; next_eol = 1'b0;
          end else begin
            if (send_idx == 4'h0) b = hdr_prio;
            else if (send_idx == 4'h1) b = hdr_tgt;
            else if (send_idx == 4'h2) b = hdr_src;
            else if (send_idx < {1'b0, nbytes} + obdp_pkg::HDR_BYTES)
              b = req[3'(send_idx - obdp_pkg::HDR_BYTES)];
            next_bus_tx_last = send_idx == {1'b0, nbytes} + obdp_pkg::HDR_BYTES;
            // fold every byte ahead of the check byte
            if (!next_bus_tx_last) next_cks = cks_fold(cks_sel, cks, b);
            next_bus_tx_data = b; next_bus_tx_valid = 1'b1; next_send_idx = send_idx + 4'h1;
          end
        end
      end
      obdp_pkg::OBDP_LISTEN: begin
        if (bus_rx_valid && bus_rx_ready) begin
          // capture the latest message, up to 12 bytes, for a later dump
          if (bus_rx_first) begin
            next_cap[0] = bus_rx_data; next_cap_len = 4'h1;
            next_msg_act = 1'b1; next_msg_match = 1'b0; next_pend_v = 1'b0;
          end else if (cap_len < 4'(obdp_pkg::CAP_DEPTH)) begin
            next_cap[cap_len] = bus_rx_data; next_cap_len = cap_len + 4'h1;
          end
          if (pos != 4'hf) next_msg_pos = pos + 4'h1;
          if (match_now) begin
            next_msg_match = 1'b1; next_tmo_cnt = tmo_load; next_got_any = 1'b1;
          end
          // forward only addressed data, holding one byte back for the check byte
          if (pos >= 4'h3 && msg_match) begin
            if (pend_v) begin
              next_cur = pend; next_ph = 2'h0; next_st = obdp_pkg::OBDP_HEXOUT;
            end
            next_pend = bus_rx_data; next_pend_v = 1'b1;
          end
          if (bus_rx_last) begin
            next_msg_act = 1'b0; next_pend_v = 1'b0; next_msg_match = 1'b0;
            if (msg_match || match_now) begin
              next_eol = 1'b1;
              if (!(pos >= 4'h3 && msg_match && pend_v)) begin
                next_st = obdp_pkg::OBDP_HEXOUT; next_ph = 2'h3;
              end
            end
          end
        end else if (tick && tmo_cnt <= 8'h01 && !msg_act) begin
          next_st = obdp_pkg::OBDP_TEXT; next_txt_idx = 4'h0;
          next_txt_sel = got_any ? obdp_pkg::TXT_EOL : obdp_pkg::TXT_NODATA;
        end else if (tick && tmo_cnt != 8'h00) begin
          next_tmo_cnt = tmo_cnt - 8'h01;
        end
      end
      obdp_pkg::OBDP_HEXOUT: begin
        if (!host_tx_valid || host_tx_ready) begin
          next_host_tx_valid = 1'b1;
          unique case (ph)
            2'h0: begin next_host_tx_data = hex_ascii(cur[7:4]); next_ph = 2'h1; end
            2'h1: begin next_host_tx_data = hex_ascii(cur[3:0]); next_ph = 2'h2; end
            2'h2: begin
              next_host_tx_data = obdp_pkg::CH_SP; next_ph = 2'h3;
              if (!eol) next_st = obdp_pkg::OBDP_LISTEN;
            end
            2'h3: begin
              next_host_tx_data = obdp_pkg::CH_CR; next_eol = 1'b0;
              next_st = obdp_pkg::OBDP_LISTEN;
            end
          endcase
        end
      end
      default: next_st = obdp_pkg::OBDP_TEXT;
    endcase
    next_bus_rx_ready = next_st == obdp_pkg::OBDP_LISTEN;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= obdp_pkg::OBDP_TEXT;
      for (int i = 0; i < 7; i++) req[i] <= 8'h00;
      for (int i = 0; i < obdp_pkg::CAP_DEPTH; i++) cap[i] <= 8'h00;
      cap_len <= 4'h0; dig_cnt <= 4'h0; send_idx <= 4'h0; msg_pos <= 4'h0;
      txt_idx <= 4'h0; hi <= 4'h0; nbytes <= 3'h0; nsp <= 2'h0;
      txt_sel <= obdp_pkg::TXT_PROMPT; ph <= 2'h0; err <= 1'b0; first_a <= 1'b0;
      is_at <= 1'b0; got_any <= 1'b0; msg_act <= 1'b0; msg_match <= 1'b0;
      pend_v <= 1'b0; eol <= 1'b0; tmo_cnt <= 8'h00; cks <= 8'h00; pend <= 8'h00;
      cur <= 8'h00; host_tx_data <= 8'h00; host_tx_valid <= 1'b0; bus_tx_data <= 8'h00;
      bus_tx_valid <= 1'b0; bus_tx_last <= 1'b0; bus_rx_ready <= 1'b0;
      cmd_line <= 1'b0; cap_rd_data <= 8'h00;
    end else begin
      st <= next_st; req <= next_req; cap <= next_cap; cap_len <= next_cap_len;
      dig_cnt <= next_dig_cnt; send_idx <= next_send_idx; msg_pos <= next_msg_pos;
      txt_idx <= next_txt_idx; hi <= next_hi; nbytes <= next_nbytes; nsp <= next_nsp;
      txt_sel <= next_txt_sel; ph <= next_ph; err <= next_err; first_a <= next_first_a;
      is_at <= next_is_at; got_any <= next_got_any; msg_act <= next_msg_act;
      msg_match <= next_msg_match; pend_v <= next_pend_v; eol <= next_eol;
      tmo_cnt <= next_tmo_cnt; cks <= next_cks; pend <= next_pend; cur <= next_cur;
      host_tx_data <= next_host_tx_data; host_tx_valid <= next_host_tx_valid;
      bus_tx_data <= next_bus_tx_data; bus_tx_valid <= next_bus_tx_valid;
      bus_tx_last <= next_bus_tx_last; bus_rx_ready <= next_bus_rx_ready;
      cmd_line <= next_cmd_line; cap_rd_data <= next_cap_rd_data;
    end
  end

  // checking helpers: frame byte count and an independent check byte
  logic [3:0] sent_cnt;
  logic [7:0] cks_ref;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_cnt <= 4'h0;
      cks_ref <= 8'h00;
    end else if (st != obdp_pkg::OBDP_SEND) begin
      sent_cnt <= 4'h0;
      cks_ref <= 8'h00;
    end else if (bus_tx_valid && bus_tx_ready) begin
      sent_cnt <= sent_cnt + 4'h1;
      if (!bus_tx_last) cks_ref <= cks_fold(cks_sel, cks_ref, bus_tx_data);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic cr_in;
  assign cr_in = st == obdp_pkg::OBDP_COLLECT && host_rx_valid && host_rx_data == obdp_pkg::CH_CR;

  chk_hold_until_cr: assert property (
    st == obdp_pkg::OBDP_COLLECT && !cr_in |=> st == obdp_pkg::OBDP_COLLECT)
    else $error("line evaluated without carriage return");
  chk_at_local: assert property (
    cr_in && is_at |=> cmd_line && st == obdp_pkg::OBDP_TEXT ##1 !bus_tx_valid)
    else $error("local command line not kept local");
  chk_odd_reject: assert property (
    cr_in && !is_at && nsp != 2'h0 && (dig_cnt[0] || dig_cnt > obdp_pkg::MAX_DIGITS)
    |=> st == obdp_pkg::OBDP_TEXT && txt_sel == obdp_pkg::TXT_ERR)
    else $error("bad length line not rejected");
  chk_bad_digit: assert property (
    st == obdp_pkg::OBDP_COLLECT && host_rx_valid && host_rx_data != obdp_pkg::CH_SP
    && host_rx_data != obdp_pkg::CH_CR && !hv[4] |=> err)
    else $error("non-hex character not flagged");
  chk_frame_len: assert property (
    st == obdp_pkg::OBDP_SEND ##1 st == obdp_pkg::OBDP_LISTEN
    |-> sent_cnt == {1'b0, nbytes} + obdp_pkg::FRAME_EXTRA)
    else $error("frame byte count wrong");
  chk_cks_last: assert property (
    bus_tx_valid && bus_tx_last |-> bus_tx_data == cks_ref)
    else $error("check byte mismatch");
  chk_no_data: assert property (
    st == obdp_pkg::OBDP_LISTEN && tick && tmo_cnt <= 8'h01 && !msg_act && !got_any
    && !(bus_rx_valid && bus_rx_ready)
    |=> st == obdp_pkg::OBDP_TEXT && txt_sel == obdp_pkg::TXT_NODATA)
    else $error("silent timeout gave no NO DATA");
  chk_tmo_restart: assert property (
    match_now |=> tmo_cnt == $past(tmo_load) && got_any)
    else $error("timeout not restarted on match");
  chk_drop_foreign: assert property (
    st == obdp_pkg::OBDP_LISTEN && !msg_match && !match_now |=> st != obdp_pkg::OBDP_HEXOUT)
    else $error("foreign message forwarded");
  chk_prompt_char: assert property (
    st == obdp_pkg::OBDP_TEXT ##1 st == obdp_pkg::OBDP_COLLECT |-> host_tx_data == obdp_pkg::CH_GT)
    else $error("ready without prompt");

  cov_request_sent: cover property (st == obdp_pkg::OBDP_SEND ##1 st == obdp_pkg::OBDP_LISTEN);
  cov_no_data: cover property (st == obdp_pkg::OBDP_TEXT && txt_sel == obdp_pkg::TXT_NODATA);
  cov_forward: cover property (st == obdp_pkg::OBDP_HEXOUT && ph == 2'h0);
  cov_reject: cover property (st == obdp_pkg::OBDP_TEXT && txt_sel == obdp_pkg::TXT_ERR);
endmodule

/* hw/obdp_pkg.sv */
// shared constants, state type and the 4 ms tick divider
// assumes one ref_clk domain at 10 MHz and an active-low async reset
`timescale 1ns/1ps
package obdp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 4;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [3:0] MAX_DIGITS = 4'he;
  localparam logic [3:0] DIG_OVER = 4'hf;
  localparam logic [3:0] HDR_BYTES = 4'h3;
  localparam logic [3:0] FRAME_EXTRA = 4'h4;
  localparam int CAP_DEPTH = 12;
  localparam logic [1:0] TXT_PROMPT = 2'h0;
  localparam logic [1:0] TXT_ERR = 2'h1;
  localparam logic [1:0] TXT_NODATA = 2'h2;
  localparam logic [1:0] TXT_EOL = 2'h3;
  localparam logic CKS_SUM = 1'b0;
  typedef enum logic [2:0] {
    OBDP_COLLECT = 3'b000,
    OBDP_TEXT = 3'b001,
    OBDP_SEND = 3'b010,
    OBDP_LISTEN = 3'b011,
    OBDP_HEXOUT = 3'b100
  } obdp_state_e;
endpackage

// one-cycle tick every TICK_CYC cycles while run is high
module obdp_tick #(
  parameter int TICK_CYC = obdp_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = 32'h0;
    next_tick = 1'b0;
    if (run && !restart) begin
      if (cnt >= 32'(TICK_CYC - 1)) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

/* sim/obdp_vehicle.sv */
// vehicle bus far side: records request frames and answers each one rep_cnt times
// assumes rising-edge sampling on ref_clk; bench sets reply address and count
`timescale 1ns/1ps
module obdp_vehicle (
  input wire logic ref_clk,
  input wire logic [7:0] bus_tx_data,
  input wire logic bus_tx_valid,
  input wire logic bus_tx_last,
  output logic bus_tx_ready,
  output logic [7:0] bus_rx_data,
  output logic bus_rx_valid,
  output logic bus_rx_first,
  output logic bus_rx_last,
  input wire logic bus_rx_ready,
  input wire logic [7:0] rep_addr,
  input wire logic [1:0] rep_cnt,
  input wire logic slow
);
  logic [7:0] frm [0:15];
  logic [7:0] msg [$];
  int frm_len = 0;
  int cur_len = 0;
  int frames = 0;
  event sent;
  initial begin
    bus_tx_ready = 1'b1;
    bus_rx_data = 8'h00;
    bus_rx_valid = 1'b0;
    bus_rx_first = 1'b0;
    bus_rx_last = 1'b0;
  end
  // slow mode stalls every other cycle
  always @(negedge ref_clk) bus_tx_ready <= slow ? ~bus_tx_ready : 1'b1;
  always @(posedge ref_clk) begin
    if (bus_tx_valid === 1'b1 && bus_tx_ready) begin
      frm[cur_len[3:0]] <= bus_tx_data;
      if (bus_tx_last === 1'b1) begin
        // length of the latest complete frame; next byte starts a new one
        frm_len <= cur_len + 1;
        cur_len <= 0;
        frames <= frames + 1;
        -> sent;
      end else begin
        cur_len <= cur_len + 1;
      end
    end
  end
  // byte held until taken; released line shows the inverse
  task automatic put(input logic [7:0] d, input logic f, input logic l);
    @(negedge ref_clk);
    bus_rx_data = d;
    bus_rx_valid = 1'b1;
    bus_rx_first = f;
    bus_rx_last = l;
    do @(posedge ref_clk); while (bus_rx_ready !== 1'b1);
  endtask
  // mode plus 40, pid echo, bitmap for pid 00
  task automatic answer();
    logic [7:0] s;
    s = 8'h00;
    msg = '{8'h48, rep_addr, 8'h10, frm[3] + 8'h40, frm[4]};
    if (frm[4] == 8'h00) msg = {msg, 8'hbe, 8'h1f, 8'hb8, 8'h10};
    else msg.push_back(8'h7b);
    foreach (msg[k]) s = s + msg[k];
    msg.push_back(s);
    foreach (msg[k]) put(msg[k], k == 0, k == msg.size() - 1);
    @(negedge ref_clk);
    bus_rx_valid = 1'b0;
    bus_rx_last = 1'b0;
    bus_rx_data = ~bus_rx_data;
  endtask
  initial forever begin
    @sent;
    repeat (3) @(posedge ref_clk);
    for (int r = 0; r < rep_cnt; r++) begin
      // gap outlasts a deadline counted from the frame end, not one restarted on match
      if (r > 0) repeat (26) @(posedge ref_clk);
      answer();
    end
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the request parser with a vehicle model
// assumes the parser header as declared; short tick divider for speed
`timescale 1ns/1ps
module testbench;
  localparam int TK = 20;
  logic ref_clk = 1'b0, rst_n = 1'b0, host_rx_valid = 1'b0, host_tx_ready = 1'b1;
  logic cks_sel = 1'b0, slow = 1'b0, hstall = 1'b0;
  logic [7:0] host_rx_data = 8'h00, own_addr = 8'hf1, timeout_arg = 8'h04;
  logic [7:0] rep_addr = 8'hf1;
  logic [1:0] rep_cnt = 2'h1;
  logic [3:0] cap_rd_idx = 4'h0;
  logic [7:0] host_tx_data, bus_tx_data, bus_rx_data, cap_rd_data;
  logic host_tx_valid, bus_tx_valid, bus_tx_last, bus_tx_ready, bus_rx_ready, cmd_line;
  logic bus_rx_valid, bus_rx_first, bus_rx_last;
  logic [3:0] cap_len;
  logic [7:0] rxq [$];
  int fails = 0, num_checks = 0, cyc = 0, t_end = 0, t_first = 0, n_cmd = 0, f0;
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) host_tx_ready <= hstall ? ~host_tx_ready : 1'b1;
  always @(posedge ref_clk) begin
    cyc++;
    if (bus_tx_valid === 1'b1 && bus_tx_ready && bus_tx_last === 1'b1) t_end = cyc;
    if (cmd_line === 1'b1) n_cmd++;
    if (host_tx_valid === 1'b1 && host_tx_ready) begin
      if (rxq.size() == 0) t_first = cyc;
      rxq.push_back(host_tx_data);
    end
  end
  obdp_parser #(.TICK_CYC(TK)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid),
    .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid),
    .host_tx_ready(host_tx_ready), .hdr_prio(8'h68), .hdr_tgt(8'h6a), .hdr_src(8'hf1),
    .own_addr(own_addr), .cks_sel(cks_sel), .timeout_arg(timeout_arg),
    .bus_tx_data(bus_tx_data), .bus_tx_valid(bus_tx_valid), .bus_tx_last(bus_tx_last),
    .bus_tx_ready(bus_tx_ready), .bus_rx_data(bus_rx_data), .bus_rx_valid(bus_rx_valid),
    .bus_rx_first(bus_rx_first), .bus_rx_last(bus_rx_last), .bus_rx_ready(bus_rx_ready),
    .cmd_line(cmd_line), .cap_rd_idx(cap_rd_idx), .cap_rd_data(cap_rd_data),
    .cap_len(cap_len));
  obdp_vehicle veh (.ref_clk(ref_clk), .bus_tx_data(bus_tx_data),
    .bus_tx_valid(bus_tx_valid), .bus_tx_last(bus_tx_last), .bus_tx_ready(bus_tx_ready),
    .bus_rx_data(bus_rx_data), .bus_rx_valid(bus_rx_valid), .bus_rx_first(bus_rx_first),
    .bus_rx_last(bus_rx_last), .bus_rx_ready(bus_rx_ready), .rep_addr(rep_addr),
    .rep_cnt(rep_cnt), .slow(slow));
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send_line(input string s);
    repeat (2) @(negedge ref_clk);
    for (int k = 0; k < s.len(); k++) begin
      host_rx_data = s[k];
      host_rx_valid = 1'b1;
      @(negedge ref_clk);
    end
    host_rx_valid = 1'b0;
  endtask
  task automatic expect_text(input string s);
    int k;
    for (k = 0; k < 5000 && rxq.size() < s.len(); k++) @(posedge ref_clk);
    if (rxq.size() < s.len()) begin
      fails++;
      close_out();
    end
    for (k = 0; k < s.len(); k++) chk(rxq[k], s[k]);
    rxq.delete();
  endtask
  task automatic check_frame(input logic [7:0] req [$]);
    logic [7:0] f [$];
    logic [7:0] c;
    f = {8'h68, 8'h6a, 8'hf1, req};
    c = 8'h00;
    foreach (f[k]) c = cks_sel ? c ^ f[k] : c + f[k];
    f.push_back(c);
    chk(veh.frm_len[7:0], 8'(f.size()));
    foreach (f[k]) chk(veh.frm[k], f[k]);
  endtask
  task automatic s_pid00();
    send_line("0 1 0 0\r");
    expect_text("41 00 BE 1F B8 10 \r\r>");
    check_frame('{8'h01, 8'h00});
    chk({4'h0, cap_len}, 8'h0a);
  endtask
  task automatic s_mismatch();
    @(negedge ref_clk);
    rep_addr = 8'h33;
    cks_sel = 1'b1;
    send_line("09 0a\r");
    expect_text("NO DATA\r\r>");
    check_frame('{8'h09, 8'h0a});
    @(negedge ref_clk);
    cap_rd_idx = 4'h1;
    repeat (2) @(negedge ref_clk);
    chk(cap_rd_data, 8'h33);
    chk({4'h0, cap_len}, 8'h07);
  endtask
  task automatic s_restart();
    @(negedge ref_clk);
    rep_addr = 8'hf1;
    rep_cnt = 2'h2;
    timeout_arg = 8'h02;
    send_line("0105\r");
    expect_text("41 05 7B \r41 05 7B \r\r>");
    check_frame('{8'h01, 8'h05});
  endtask
  task automatic s_timeout();
    @(negedge ref_clk);
    rep_cnt = 2'h0;
    timeout_arg = 8'h03;
    slow = 1'b1;
    hstall = 1'b1;
    send_line("01020304050607\r");
    expect_text("NO DATA\r\r>");
    chk(t_first - t_end >= 3 * TK && t_first - t_end <= 4 * TK + 10, 8'h01);
    check_frame('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
    slow = 1'b0;
    hstall = 1'b0;
  endtask
  task automatic s_reject();
    string bad [3] = '{"012\r", "010203040506070\r", "0102030405060708\r"};
    f0 = veh.frames;
    foreach (bad[k]) begin
      send_line(bad[k]);
      expect_text("?\r\r>");
    end
    chk(veh.frames - f0, 8'h00);
  endtask
  task automatic s_cmd();
    f0 = veh.frames;
    send_line("At rv\r");
    expect_text(">");
    chk(n_cmd, 8'h01);
    chk(veh.frames - f0, 8'h00);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    expect_text(">");
    s_pid00();
    s_mismatch();
    s_restart();
    s_timeout();
    s_reject();
    s_cmd();
    close_out();
  end
  initial begin
    #(100 * 100000);
    fails++;
    close_out();
  end
endmodule
